/* File: logic/brd_pkg.sv */
package brd_pkg;

  // ==========================================================
  // Address split
  // ==========================================================
  localparam int ADDR_W = 32;
  localparam int BANK_MSB = 31;
  localparam int BANK_LSB = 28;
  localparam int AREA_MSB = 27;
  localparam int AREA_LSB = 20;
  localparam int BANK_OFF_W = 28;
  localparam int AREA_OFF_W = 20;

  // ==========================================================
  // Banks of 256 MB, selected by the top four address bits
  // ==========================================================
  localparam logic [3:0] BANK_INTERNAL = 4'h0;
  localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
  localparam logic [3:0] BANK_EXT_LAST = 4'h7;
  localparam logic [3:0] BANK_PERIPH = 4'hf;

  // ==========================================================
  // Areas of 1 MB inside bank 0
  // ==========================================================
  localparam logic [7:0] AREA_BOOT = 8'h00;
  localparam logic [7:0] AREA_ROM = 8'h01;
  localparam logic [7:0] AREA_RAM_FIRST = 8'h02;
  localparam logic [7:0] AREA_RAM_SECOND = 8'h03;
  localparam logic [7:0] AREA_USB_HOST = 8'h05;

  // ==========================================================
  // External chip selects and boot defaults
  // ==========================================================
  localparam int NUM_CS = 8;
  localparam logic [2:0] CS_BOOT = 3'h0;
  localparam logic CS0_BYTE_SELECT = 1'b1;
  localparam logic [1:0] CS0_WIDTH_16 = 2'h1;
  localparam logic CS0_CTRL_BY_CS = 1'b1;
  localparam logic RESET_REMAP = 1'b0;

  // Slave targets of one decode
  typedef enum logic [2:0] {
    SLV_NONE = 3'h0,
    SLV_ROM = 3'h1,
    SLV_RAM_FIRST = 3'h2,
    SLV_RAM_SECOND = 3'h3,
    SLV_USB_HOST = 3'h4,
    SLV_EXT_BUS = 3'h5,
    SLV_PERIPH = 3'h6
  } brd_slave_t;

  // Request of one master
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } brd_req_t;

  // Decoded route of one master
  typedef struct packed {
    logic valid;
    logic abort;
    brd_slave_t slave;
    logic [2:0] chipSel;
    logic [BANK_OFF_W-1:0] offset;
  } brd_route_t;

  // Chip select 0 configuration after an external boot
  typedef struct packed {
    logic active;
    logic byteSelect;
    logic [1:0] busWidth;
    logic ctrlByCs;
  } brd_cs0_cfg_t;

endpackage

/* File: logic/brd_boot_strap.sv */
module brd_boot_strap (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bootSourcePin,
  input wire logic remapSetReq,
  input wire logic remapClearReq,
  output logic bootFromRom,
  output logic remapActive
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic syncFirst;
    logic syncSecond;
    logic bootLevel;
    logic remap;
  } brd_strap_state_t;

  brd_strap_state_t state_reg;
  brd_strap_state_t state_next;

  // Pin passes two flops; the level is frozen once reset is released
  always_comb begin
    state_next = state_reg;
    state_next.syncFirst = bootSourcePin;
    state_next.syncSecond = state_reg.syncFirst;
    if (rst) begin
      state_next.bootLevel = state_reg.syncSecond;
      state_next.remap = brd_pkg::RESET_REMAP;
    end else if (remapSetReq) begin
      state_next.remap = 1'b1; // Set wins over a clear in the same cycle
    end else if (remapClearReq) begin
      state_next.remap = 1'b0;
    end
  end

  // Single register stage for the whole state
  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
  end

  // Outputs straight from flops
  assign bootFromRom = state_reg.bootLevel;
  assign remapActive = state_reg.remap;

endmodule

/* File: logic/brd_decoder_top.sv */
// Functional notes
// - Top four address bits pick one of sixteen 256 MB banks.
// - Banks 1 to 7 go to the external bus, each to a chip select.
// - Bank 0 holds internal memories, split into 1 MB areas.
// - Bank 15 goes to the peripheral bridge.
// - Accesses to unmapped addresses end in an abort to the requester.
// - Every master has its own decoder; all decode identically.
// - Address zero resolves to internal boot, external boot or remapped RAM.
// - The first 1 MB belongs wholly to the selected boot memory.
// - No remap and boot pin high: boot area maps to ROM.
// - No remap and boot pin low: boot area maps to chip select 0.
// - Boot pin is captured during reset; later changes are ignored.
// - With remap set the first RAM sits at zero, pin ignored.
// - ROM, both RAMs and USB host window keep fixed addresses.
// - After reset the first fetch comes from address zero.
// - External boot gives chip select 0 byte select, 16 bits, CS strobes.
// - Each external chip select owns its own 256 MB window.
//
// Limitations: memories smaller than their 1 MB area alias inside it, and
// nothing above their size is aborted. Chip select 7 is never reached by
// the decode, since banks 1 to 7 give chip selects 0 to 6.
module brd_decoder_top #(
  parameter int NUM_MASTERS = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bootSourcePin,
  input wire logic remapSetReq,
  input wire logic remapClearReq,
  input wire brd_pkg::brd_req_t reqIn [NUM_MASTERS],
  output brd_pkg::brd_route_t routeOut [NUM_MASTERS],
  output brd_pkg::brd_cs0_cfg_t cs0Cfg,
  output logic bootFromRom,
  output logic remapActive
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  if (NUM_MASTERS < 1 || NUM_MASTERS > 16) begin : g_bad_masters
    $error("NUM_MASTERS must lie between 1 and 16");
  end
  if (int'(brd_pkg::BANK_EXT_LAST - brd_pkg::BANK_EXT_FIRST) >= brd_pkg::NUM_CS)
  begin : g_bad_cs
    $error("More external banks than chip selects");
  end
  // The decode relies on the area field sitting just below the bank field
  if (brd_pkg::BANK_LSB != brd_pkg::AREA_MSB + 1) begin : g_bad_fields
    $error("Bank and area fields must be adjacent");
  end
  // A peripheral bank inside the external range would be unreachable
  if (brd_pkg::BANK_PERIPH <= brd_pkg::BANK_EXT_LAST) begin : g_bad_banks
    $error("Peripheral bank overlaps the external banks");
  end
  // Chip select numbers must fit the three-bit route field
  if (brd_pkg::NUM_CS > 8) begin : g_bad_cs_width
    $error("Chip select field too narrow");
  end

  // ==========================================================
  // Decode function, shared by every master
  // ==========================================================
  function automatic brd_pkg::brd_route_t decodeAddr(
    input logic [brd_pkg::ADDR_W-1:0] addr,
    input logic remap,
    input logic romBoot
  );
    brd_pkg::brd_route_t r;
    logic [3:0] bank;
    logic [7:0] area;
    r = '0;
    bank = addr[brd_pkg::BANK_MSB:brd_pkg::BANK_LSB];
    area = addr[brd_pkg::AREA_MSB:brd_pkg::AREA_LSB];
    r.valid = 1'b1;
    r.slave = brd_pkg::SLV_NONE;
    r.offset = addr[brd_pkg::BANK_OFF_W-1:0];
    if (bank == brd_pkg::BANK_INTERNAL) begin
      // Second stage: 1 MB areas, offset is the place inside the area
      r.offset = {8'h00, addr[brd_pkg::AREA_OFF_W-1:0]};
      case (area)
        brd_pkg::AREA_BOOT: begin
          // Whole first megabyte follows the boot choice
          if (remap) begin
            r.slave = brd_pkg::SLV_RAM_FIRST;
          end else if (romBoot) begin
            r.slave = brd_pkg::SLV_ROM;
          end else begin
            r.slave = brd_pkg::SLV_EXT_BUS;
            r.chipSel = brd_pkg::CS_BOOT;
          end
        end
        brd_pkg::AREA_ROM: begin
          r.slave = brd_pkg::SLV_ROM;
        end
        brd_pkg::AREA_RAM_FIRST: begin
          r.slave = brd_pkg::SLV_RAM_FIRST;
        end
        brd_pkg::AREA_RAM_SECOND: begin
          r.slave = brd_pkg::SLV_RAM_SECOND;
        end
        brd_pkg::AREA_USB_HOST: begin
          r.slave = brd_pkg::SLV_USB_HOST;
        end
        default: begin
          // Empty areas of bank 0 abort as well
          r.abort = 1'b1;
        end
      endcase
    end else if (bank >= brd_pkg::BANK_EXT_FIRST && bank <= brd_pkg::BANK_EXT_LAST) begin
      // One chip select per bank, whole 256 MB window
      r.slave = brd_pkg::SLV_EXT_BUS;
      r.chipSel = 3'(bank - brd_pkg::BANK_EXT_FIRST);
    end else if (bank == brd_pkg::BANK_PERIPH) begin
      r.slave = brd_pkg::SLV_PERIPH;
    end else begin
      // Banks 8 to 14 hold nothing
      r.abort = 1'b1;
    end
    // An aborted access names no slave and carries no offset
    if (r.abort) begin
      r.offset = '0;
      r.chipSel = '0;
    end
    return r;
  endfunction

  // ==========================================================
  // Boot strap capture and remap flag
  // ==========================================================
  brd_boot_strap u_strap (
    .sys_clk(sys_clk),
    .rst(rst),
    .bootSourcePin(bootSourcePin),
    .remapSetReq(remapSetReq),
    .remapClearReq(remapClearReq),
    .bootFromRom(bootFromRom),
    .remapActive(remapActive)
  );

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    brd_pkg::brd_route_t [NUM_MASTERS-1:0] route;
    brd_pkg::brd_cs0_cfg_t cs0;
  } brd_top_state_t;

  brd_top_state_t state_reg;
  brd_top_state_t state_next;

  // One decoder per master; identical function keeps maps equal
  always_comb begin
    state_next = state_reg;
    for (int m = 0; m < NUM_MASTERS; m++) begin
      if (rst) begin
        state_next.route[m] = '0;
      end else if (reqIn[m].valid) begin
        state_next.route[m] = decodeAddr(reqIn[m].addr, remapActive, bootFromRom);
      end else begin
        // Idle lanes drop to zero so no stale answer looks like a new one
        state_next.route[m] = '0;
      end
    end
    // Chip select 0 defaults are always driven; active is set only while booting from the external bus
    state_next.cs0.byteSelect = brd_pkg::CS0_BYTE_SELECT;
    state_next.cs0.busWidth = brd_pkg::CS0_WIDTH_16;
    state_next.cs0.ctrlByCs = brd_pkg::CS0_CTRL_BY_CS;
    state_next.cs0.active = rst ? 1'b0 : !bootFromRom;
  end

  // Single register stage; reset is applied through the next value
  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
  end

  // Outputs straight from flops
  assign cs0Cfg = state_reg.cs0;
  for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_out
    assign routeOut[m] = state_reg.route[m];
  end

  // ==========================================================
  // Helper slices for the checks below
  // ==========================================================
  // Written out by hand so the checks do not reuse the decode function
  logic [3:0] reqBank [NUM_MASTERS];
  logic [7:0] reqArea [NUM_MASTERS];
  logic [brd_pkg::BANK_OFF_W-1:0] reqBankOff [NUM_MASTERS];
  logic [brd_pkg::AREA_OFF_W-1:0] reqAreaOff [NUM_MASTERS];
  for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_slice
    assign reqBank[m] = reqIn[m].addr[brd_pkg::BANK_MSB:brd_pkg::BANK_LSB];
    assign reqArea[m] = reqIn[m].addr[brd_pkg::AREA_MSB:brd_pkg::AREA_LSB];
    assign reqBankOff[m] = reqIn[m].addr[brd_pkg::BANK_OFF_W-1:0];
    assign reqAreaOff[m] = reqIn[m].addr[brd_pkg::AREA_OFF_W-1:0];
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Strap frozen after release; remap cleared by reset
  a_strap_frozen: assert property (1'b1 |=> $stable(bootFromRom))
    else $error("Boot source level changed after reset");
  a_remap_cleared: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    rst |=> !remapActive)
    else $error("Remap flag not cleared by reset");
  a_cs0_defaults: assert property (
    !bootFromRom |=> cs0Cfg.active && cs0Cfg.byteSelect
      && cs0Cfg.busWidth == brd_pkg::CS0_WIDTH_16 && cs0Cfg.ctrlByCs)
    else $error("Chip select 0 boot defaults missing");
  a_cs0_idle_rom: assert property (bootFromRom |=> !cs0Cfg.active)
    else $error("Chip select 0 defaults active on internal boot");
  a_cs0_consts: assert property (
    1'b1 |=> cs0Cfg.byteSelect == brd_pkg::CS0_BYTE_SELECT
      && cs0Cfg.ctrlByCs == brd_pkg::CS0_CTRL_BY_CS)
    else $error("Chip select 0 fixed fields changed");

  // ==========================================================
  // Remap flag checks
  // ==========================================================
  // Requests come from logic on this clock and act one cycle later;
  // a set beats a clear so a racing clear cannot undo a fresh remap
  a_remap_set: assert property (remapSetReq |=> remapActive)
    else $error("Remap request not taken");
  a_remap_clear: assert property (
    !remapSetReq && remapClearReq |=> !remapActive)
    else $error("Remap clear not taken");
  a_remap_hold: assert property (
    !remapSetReq && !remapClearReq |=> $stable(remapActive))
    else $error("Remap flag moved on its own");

  // ==========================================================
  // Map checks, one set per master
  // ==========================================================

  for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_chk
    sequence s_req(logic [3:0] b);
      reqIn[m].valid && reqBank[m] == b;
    endsequence
    sequence s_boot_req;
      reqIn[m].valid && reqBank[m] == brd_pkg::BANK_INTERNAL
        && reqArea[m] == brd_pkg::AREA_BOOT;
    endsequence
    sequence s_area_req(logic [7:0] a);
      reqIn[m].valid && reqBank[m] == brd_pkg::BANK_INTERNAL && reqArea[m] == a;
    endsequence

    a_idle_quiet: assert property (!reqIn[m].valid |=> !routeOut[m].valid)
      else $error("Route valid without a request");
    a_ext_route: assert property (
      reqIn[m].valid && reqBank[m] >= brd_pkg::BANK_EXT_FIRST
        && reqBank[m] <= brd_pkg::BANK_EXT_LAST
      |=> routeOut[m].valid && routeOut[m].slave == brd_pkg::SLV_EXT_BUS
        && routeOut[m].chipSel == 3'($past(reqBank[m]) - brd_pkg::BANK_EXT_FIRST)
        && routeOut[m].offset == $past(reqBankOff[m]))
      else $error("External bank routed wrongly");
    a_periph_route: assert property (
      s_req(brd_pkg::BANK_PERIPH)
      |=> routeOut[m].slave == brd_pkg::SLV_PERIPH && !routeOut[m].abort)
      else $error("Peripheral bank not routed to bridge");
    a_unused_abort: assert property (
      reqIn[m].valid && reqBank[m] > brd_pkg::BANK_EXT_LAST
        && reqBank[m] < brd_pkg::BANK_PERIPH
      |=> routeOut[m].valid && routeOut[m].abort
        && routeOut[m].slave == brd_pkg::SLV_NONE)
      else $error("Unused bank not aborted");
    a_hole_abort: assert property (
      reqIn[m].valid && reqBank[m] == brd_pkg::BANK_INTERNAL
        && ((reqArea[m] > brd_pkg::AREA_RAM_SECOND && reqArea[m] < brd_pkg::AREA_USB_HOST)
          || reqArea[m] > brd_pkg::AREA_USB_HOST)
      |=> routeOut[m].abort)
      else $error("Empty internal area not aborted");
    a_boot_rom: assert property (
      s_boot_req and (!remapActive && bootFromRom)
      |=> routeOut[m].slave == brd_pkg::SLV_ROM
        && routeOut[m].offset == 28'($past(reqAreaOff[m])))
      else $error("Boot area not on ROM");
    a_boot_ext: assert property (
      s_boot_req and (!remapActive && !bootFromRom)
      |=> routeOut[m].slave == brd_pkg::SLV_EXT_BUS
        && routeOut[m].chipSel == brd_pkg::CS_BOOT)
      else $error("Boot area not on chip select 0");
    a_remap_ram: assert property (
      s_boot_req and remapActive
      |=> routeOut[m].slave == brd_pkg::SLV_RAM_FIRST)
      else $error("Remapped boot area not on first RAM");
    a_fixed_map: assert property (
      s_area_req(brd_pkg::AREA_ROM) |=> routeOut[m].slave == brd_pkg::SLV_ROM)
      else $error("ROM window moved");
    a_fixed_rams: assert property (
      s_area_req(brd_pkg::AREA_RAM_SECOND) or s_area_req(brd_pkg::AREA_USB_HOST)
      |=> routeOut[m].slave inside {brd_pkg::SLV_RAM_SECOND, brd_pkg::SLV_USB_HOST}
        && !routeOut[m].abort)
      else $error("Fixed internal window moved");
    a_ram_window: assert property (
      s_area_req(brd_pkg::AREA_RAM_FIRST)
      |=> routeOut[m].slave == brd_pkg::SLV_RAM_FIRST && !routeOut[m].abort)
      else $error("First RAM window moved");
    a_usb_window: assert property (
      s_area_req(brd_pkg::AREA_USB_HOST)
      |=> routeOut[m].slave == brd_pkg::SLV_USB_HOST && !routeOut[m].abort)
      else $error("USB host window moved");
    a_area_offset: assert property (
      s_area_req(brd_pkg::AREA_ROM)
      |=> routeOut[m].offset == 28'($past(reqAreaOff[m])))
      else $error("Area offset lost");
    // Every request is answered exactly one cycle later
    a_answer_due: assert property (reqIn[m].valid |=> routeOut[m].valid)
      else $error("Request got no answer");
    // An abort must not leak a target that a slave could act on
    a_abort_clean: assert property (
      routeOut[m].abort |-> routeOut[m].valid && routeOut[m].slave == brd_pkg::SLV_NONE
        && routeOut[m].chipSel == 3'h0 && routeOut[m].offset == '0)
      else $error("Aborted route carries a target");
    a_mapped_slave: assert property (
      routeOut[m].valid && !routeOut[m].abort |-> routeOut[m].slave != brd_pkg::SLV_NONE)
      else $error("Accepted route names no slave");
    a_periph_offset: assert property (
      s_req(brd_pkg::BANK_PERIPH) |=> routeOut[m].offset == $past(reqBankOff[m]))
      else $error("Peripheral offset lost");
    a_boot_offset: assert property (
      s_boot_req |=> routeOut[m].valid && !routeOut[m].abort
        && routeOut[m].offset == 28'($past(reqAreaOff[m])))
      else $error("Boot area not wholly mapped");
    a_ext_cs_range: assert property (
      routeOut[m].valid && routeOut[m].slave == brd_pkg::SLV_EXT_BUS
      |-> routeOut[m].chipSel < 3'(brd_pkg::NUM_CS - 1))
      else $error("Chip select outside the decoded range");
    // Reset clears every lane, whatever stood on the bus before
    a_reset_quiet: assert property (
      @(posedge sys_clk) disable iff (1'b0)
      rst |=> routeOut[m] == '0)
      else $error("Route not cleared by reset");
    if (m > 0) begin : g_same
      a_same_decode: assert property (
        reqIn[m] == reqIn[0] |=> routeOut[m] == routeOut[0])
        else $error("Masters decode differently");
    end
  end

endmodule

/* File: tb/brd_master_model.sv */
// ==========================================================
// Bus master side: one request lane per master
// ==========================================================
module brd_master_model #(
  parameter int NM = 6
) (
  input wire logic sys_clk,
  input wire logic cmdValid [NM],
  input wire logic [31:0] cmdAddr [NM],
  output brd_pkg::brd_req_t reqOut [NM]
);
  timeunit 1ns;
  timeprecision 1ps;
  // Start idle so the decoder never sees an unknown request
  initial begin
    for (int m = 0; m < NM; m++) begin
      reqOut[m] = '0;
    end
  end

  // Launch on the falling edge; an idle lane inverts its address every cycle,
  // so a decoder that ignores valid would show a changing route
  always @(negedge sys_clk) begin
    for (int m = 0; m < NM; m++) begin
      reqOut[m].valid <= cmdValid[m];
      reqOut[m].addr <= cmdValid[m] ? cmdAddr[m] : ~reqOut[m].addr;
    end
  end
endmodule

/* File: tb/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NM = 6;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic bootSourcePin = 1'b1;
  logic remapSetReq = 1'b0;
  logic remapClearReq = 1'b0;
  logic cmdValid [NM];
  logic [31:0] cmdAddr [NM];
  brd_pkg::brd_req_t reqIn [NM];
  brd_pkg::brd_route_t routeOut [NM];
  brd_pkg::brd_cs0_cfg_t cs0Cfg;
  logic bootFromRom;
  logic remapActive;
  logic expRemap = 1'b0;
  logic expRom = 1'b1;
  int miscompares = 0;
  int checkCount = 0;

  // ==========================================================
  // Clock, partner and design
  // ==========================================================
  always #20 sys_clk = ~sys_clk;

  // Lanes idle at time zero
  initial begin
    for (int m = 0; m < NM; m++) begin
      cmdValid[m] = 1'b0;
      cmdAddr[m] = 32'h0000_0000;
    end
  end

  brd_master_model #(.NM(NM)) masters (.sys_clk(sys_clk), .cmdValid(cmdValid),
    .cmdAddr(cmdAddr), .reqOut(reqIn));

  brd_decoder_top #(.NUM_MASTERS(NM)) uut (.sys_clk(sys_clk), .rst(rst),
    .bootSourcePin(bootSourcePin), .remapSetReq(remapSetReq),
    .remapClearReq(remapClearReq), .reqIn(reqIn), .routeOut(routeOut),
    .cs0Cfg(cs0Cfg), .bootFromRom(bootFromRom), .remapActive(remapActive));

  // ==========================================================
  // Reference map and helpers
  // ==========================================================
  function automatic brd_pkg::brd_route_t expRoute(logic [31:0] a, logic rm, logic rom);
    brd_pkg::brd_route_t r;
    r = '0;
    r.valid = 1'b1;
    r.offset = a[27:0];
    r.abort = 1'b1;
    if (a[31:28] == 4'h0) begin
      r.offset = {8'h00, a[19:0]};
      r.abort = 1'b0;
      case (a[27:20])
        8'h00: begin
          if (rm) begin
            r.slave = brd_pkg::SLV_RAM_FIRST;
          end else begin
            r.slave = rom ? brd_pkg::SLV_ROM : brd_pkg::SLV_EXT_BUS;
          end
        end
        8'h01: r.slave = brd_pkg::SLV_ROM;
        8'h02: r.slave = brd_pkg::SLV_RAM_FIRST;
        8'h03: r.slave = brd_pkg::SLV_RAM_SECOND;
        8'h05: r.slave = brd_pkg::SLV_USB_HOST;
        default: r.abort = 1'b1;
      endcase
    end else if (a[31:28] <= 4'h7) begin
      r.abort = 1'b0;
      r.slave = brd_pkg::SLV_EXT_BUS;
      r.chipSel = 3'(a[31:28] - 4'h1);
    end else if (a[31:28] == 4'hf) begin
      r.abort = 1'b0;
      r.slave = brd_pkg::SLV_PERIPH;
    end
    // An unmapped access carries no slave and no offset
    if (r.abort) begin
      r.slave = brd_pkg::SLV_NONE;
      r.offset = '0;
    end
    return r;
  endfunction

  task automatic chk(input logic ok, input string msg);
    checkCount++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic testDone();
    $display("miscompares=%0d checks=%0d", miscompares, checkCount);
    if (miscompares == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // All masters request at once, each with its own offset; the answer must
  // stand for exactly one cycle
  task automatic issue(input logic [31:0] base);
    int n;
    brd_pkg::brd_route_t want;
    @(negedge sys_clk);
    for (int m = 0; m < NM; m++) begin
      cmdValid[m] <= 1'b1;
      cmdAddr[m] <= base | 32'(m << 4);
    end
    @(negedge sys_clk);
    for (int m = 0; m < NM; m++) begin
      cmdValid[m] <= 1'b0;
    end
    n = 0;
    while (routeOut[0].valid !== 1'b1 && n < 4) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    for (int m = 0; m < NM; m++) begin
      want = expRoute(base | 32'(m << 4), expRemap, expRom);
      chk(routeOut[m] === want, $sformatf("route master %0d addr %h", m, base));
    end
    @(posedge sys_clk);
    #1;
    chk(routeOut[0].valid === 1'b0, "answer longer than one cycle");
  endtask

  // Every master asks for one address; all decoders must answer alike
  task automatic issueSame(input logic [31:0] addr);
    @(negedge sys_clk);
    for (int m = 0; m < NM; m++) begin
      cmdValid[m] <= 1'b1;
      cmdAddr[m] <= addr;
    end
    @(negedge sys_clk);
    for (int m = 0; m < NM; m++) begin
      cmdValid[m] <= 1'b0;
    end
    @(posedge sys_clk);
    #1;
    for (int m = 0; m < NM; m++) begin
      chk(routeOut[m] === expRoute(addr, expRemap, expRom), "same address decode");
    end
  endtask

  task automatic pulseRemap(input logic setIt, input logic clrIt);
    @(negedge sys_clk);
    remapSetReq <= setIt;
    remapClearReq <= clrIt;
    @(negedge sys_clk);
    remapSetReq <= 1'b0;
    remapClearReq <= 1'b0;
    expRemap = setIt | (expRemap & ~clrIt);
    @(negedge sys_clk);
    chk(remapActive === expRemap, "remap flag");
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic resetRun(input logic pin);
    @(negedge sys_clk);
    bootSourcePin <= pin;
    rst <= 1'b1;
    repeat (10) @(negedge sys_clk);
    rst <= 1'b0;
    expRom = pin;
    expRemap = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(bootFromRom === pin, "captured boot level");
    chk(remapActive === 1'b0, "remap after reset");
    chk(cs0Cfg === {~pin, 1'b1, 2'h1, 1'b1}, "chip select 0 boot setup");
    issue(32'h0000_0000);
  endtask

  task automatic testBanks();
    for (int b = 0; b < 16; b++) begin
      issue({4'(b), 28'h0abc_de0});
    end
  endtask

  task automatic testAreas();
    for (int a = 0; a < 8; a++) begin
      issue({4'h0, 8'(a), 20'h0_1230});
    end
    issue(32'h0ff0_0000);
    issue(32'h000f_ff00);
  endtask

  // Pin moves after reset; the mapping must not follow it
  task automatic testPinFrozen();
    @(negedge sys_clk);
    bootSourcePin <= ~expRom;
    repeat (4) @(negedge sys_clk);
    chk(bootFromRom === expRom, "boot level moved");
    issue(32'h0000_0000);
  endtask

  // Remap only once booted; set wins over a clear in the same cycle
  task automatic testRemap();
    pulseRemap(1'b1, 1'b0);
    issue(32'h0000_0100);
    issue(32'h0010_0000);
    pulseRemap(1'b1, 1'b1);
    pulseRemap(1'b0, 1'b1);
    issue(32'h0000_0000);
    pulseRemap(1'b1, 1'b0);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial begin
    resetRun(1'b1);
    testBanks();
    issueSame(32'h3000_0010);
    testAreas();
    testPinFrozen();
    testRemap();
    resetRun(1'b0);
    issue(32'h1000_0000);
    issueSame(32'h0000_0200);
    issue(32'hf000_0040);
    // Retiming chip select 0 is left to software; until then the defaults stand
    chk(cs0Cfg === {1'b1, 1'b1, 2'h1, 1'b1}, "chip select 0 setup lost");
    testRemap();
    issueSame(32'h0000_0000);
    testDone();
  end

  // The run needs well under 1000 cycles
  initial begin
    #(40 * 5000);
    miscompares++;
    testDone();
  end
endmodule
